// ===== pkg/ppl_defs.vh
// Constants for the palette pixel-latch and host-width block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PPL_DEFS_VH
`define PPL_DEFS_VH

// ****************************************************************
// Register select codes
// ****************************************************************
`define PPL_REG_WADDR     4'h0
`define PPL_REG_HOLD      4'h1
`define PPL_REG_MASK      4'h2
`define PPL_REG_RADDR     4'h3
`define PPL_REG_GCTL      4'h8
`define PPL_REG_OCLK      4'hA
`define PPL_REG_MUXC      4'hB

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PPL_GCTL_NIB      3
`define PPL_GCTL_SPLIT    2
`define PPL_OCLK_SCLK     2:0
`define PPL_OCLK_VIDEO_SYNC_CLOCK_OUT     5:3
`define PPL_PAL_IDX       3:0
`define PPL_HOST_LOW6     5:0
`define PPL_MUX_PASSTHRU  8'h2D
`define PPL_GCTL_RST      8'h00
`define PPL_OCLK_RST      8'h00
`define PPL_MUXC_RST      8'h00
`define PPL_MASK_RST      8'hFF
`define PPL_BYTE_ZERO     8'h00

// ****************************************************************
// Sizes and sequence codes
// ****************************************************************
`define PPL_DIV_W         3
`define PPL_PAL_AW        4
`define PPL_PAL_DEPTH     16
`define PPL_COLOR_W       24
`define PPL_CNT_RED       2'h0
`define PPL_CNT_GRN       2'h1
`define PPL_CNT_BLUE      2'h2
`define PPL_SYNC_W        4

`endif

// ===== core/ppl_sync3.v
// Three-stage synchroniser with agreement filter for outside inputs.
// Assumes the inputs are asynchronous to clock; output changes once
// the second and third stages agree.
module ppl_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             resetn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer         i;

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            stage1   <= {WIDTH{1'b0}};
            stage2   <= {WIDTH{1'b0}};
            stage3   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // Stage one feeds only stage two; glitches need two agreeing samples
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage2[i] == stage3[i])
                    sync_out[i] <= stage3[i];
            end
        end
    end

endmodule

// ===== core/ppl_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Output word and valid come straight from flops; input ready is the
// inverse of the skid flop, so a stall downstream costs no word.
module ppl_buf2 #(
    parameter WIDTH = 24
) (
    input  wire             clock,
    input  wire             resetn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] skid_data;
    reg             skid_valid;

    assign in_ready = ~skid_valid;

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            out_data   <= {WIDTH{1'b0}};
            out_valid  <= 1'b0;
            skid_data  <= {WIDTH{1'b0}};
            skid_valid <= 1'b0;
        end
        else if (out_ready || !out_valid)
        begin
            if (skid_valid)
            begin
                out_data   <= skid_data;
                out_valid  <= 1'b1;
                skid_valid <= 1'b0;
            end
            else
            begin
                out_data  <= in_data;
                out_valid <= in_valid;
            end
        end
        else if (in_valid && !skid_valid)
        begin
            skid_data  <= in_data;
            skid_valid <= 1'b1;
        end
    end

endmodule

// ===== core/ppl_top.v
// Pixel latch, shift/video clock generation and host width path of a
// colour palette. Assumes clock is the dot clock; the width, flag and
// blanking pins are asynchronous and are synchronised here.
//
// How it works
// - General control bits 3=0, 2=1 make the flag a split transfer request.
// - Flag rising during blanking in split mode adds one shift-clock cycle.
// - Bits 3=1, 2=0 select nibble mode; flag sampled at video clock fall.
// - Sampled high latches upper nibbles at next shift rise, low the lower.
// - Both bits clear ignores the flag; software never sets both.
// - Pass-through mode takes pixels from the 8-bit bus, unmultiplexed.
// - Host write strobe stores data into the addressed register.
// - Width select high: host transfers use all eight data bits.
// - Width select low: stored bits 5..0 reach DAC as 7..2, low two zero.
// - Width select low: holding register reads return top two bits zero.
// - A programmable video clock output lets a processor sync pixels.
// - Pass-through uses the alternate blanking input, other modes normal.
// - Shift clock divides the dot clock, held off in blanking but extra.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`include "ppl_defs.vh"

module ppl_top (
    input  wire        clock,
    input  wire        resetn,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        width_select_in,
    input  wire        split_or_nibble_flag,
    input  wire        blank_n_in,
    input  wire        alternate_retrace_gate_in,
    input  wire [31:0] pixel_bus,
    input  wire [7:0]  passthru_bus,
    output reg         shift_clock_out,
    output reg         video_sync_clock_out,
    output wire [23:0] dac_data,
    output wire        dac_valid,
    input  wire        dac_ready
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Colour word to DAC: in 6-bit mode each channel moves up two bits
    function [23:0] dac_fmt;
        input [23:0] rgb;
        input        wide;
        begin
            if (wide)
                dac_fmt = rgb;
            else
                dac_fmt = {rgb[21:16], 2'b00, rgb[13:8], 2'b00, rgb[5:0], 2'b00};
        end
    endfunction

    function [3:0] nib_pick;
        input [7:0] pbyte;
        input       upper;
        begin
            nib_pick = upper ? pbyte[7:4] : pbyte[3:0];
        end
    endfunction

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg  [7:0]               reg_gctl;
    reg  [7:0]               reg_oclk;
    reg  [7:0]               reg_muxc;
    reg  [7:0]               reg_mask;
    reg  [`PPL_PAL_AW-1:0]   wr_addr;
    reg  [`PPL_PAL_AW-1:0]   rd_addr;
    reg  [1:0]               wr_cnt;
    reg  [1:0]               rd_cnt;
    reg  [7:0]               wr_red;
    reg  [7:0]               wr_grn;
    reg  [23:0]              rd_hold;
    reg  [23:0]              palette [0:`PPL_PAL_DEPTH-1];
    reg  [`PPL_DIV_W-1:0]    sclk_cnt;
    reg  [`PPL_DIV_W-1:0]    video_sync_clock_out_cnt;
    reg                      flag_q;
    reg                      extra_pend;
    reg                      nibble_sel;
    reg  [7:0]               hold_byte;

    wire [`PPL_SYNC_W-1:0]   pins_s;
    wire                     wide_s;
    wire                     flag_s;
    wire                     blank_n_s;
    wire                     alt_gate_s;
    wire                     passthru;
    wire                     split_mode;
    wire                     nib_mode;
    wire                     blank_act;
    wire                     flag_rise;
    wire                     sclk_run;
    wire                     buf_in_ready;
    wire                     adv;
    wire                     sclk_hit;
    wire                     sclk_rise;
    wire                     sclk_fall;
    wire                     video_sync_clock_out_hit;
    wire                     video_sync_clock_out_fall;
    wire                     extra_set;
    wire                     extra_clr;
    wire [3:0]               pix_idx;
    wire [3:0]               pal_idx;
    wire                     pix_push;
    wire [23:0]              pix_word;
    wire                     wr_blue;
    wire                     rd_blue;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    ppl_sync3 #(
        .WIDTH    (`PPL_SYNC_W)
    ) u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .async_in ({width_select_in, split_or_nibble_flag,
                    blank_n_in, alternate_retrace_gate_in}),
        .sync_out (pins_s)
    );

    assign wide_s     = pins_s[3];
    assign flag_s     = pins_s[2];
    assign blank_n_s  = pins_s[1];
    assign alt_gate_s = pins_s[0];

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    assign passthru   = (reg_muxc == `PPL_MUX_PASSTHRU);
    // Both bits set is not a legal setting; it falls to the ignored case
    assign split_mode = ~reg_gctl[`PPL_GCTL_NIB] & reg_gctl[`PPL_GCTL_SPLIT];
    assign nib_mode   = reg_gctl[`PPL_GCTL_NIB] & ~reg_gctl[`PPL_GCTL_SPLIT];
    assign blank_act  = passthru ? alt_gate_s : ~blank_n_s;
    assign flag_rise  = flag_s & ~flag_q;

    // ****************************************************************
    // Shift and video clock generation
    // ****************************************************************
    assign extra_set = split_mode & blank_act & flag_rise;
    assign extra_clr = sclk_fall & blank_act;
    assign sclk_run  = ~blank_act | extra_pend;
    // A full output buffer freezes the shift clock so no pixel is lost
    assign adv       = sclk_run & buf_in_ready;
    assign sclk_hit  = (sclk_cnt == reg_oclk[`PPL_OCLK_SCLK]);
    assign sclk_rise = adv & sclk_hit & ~shift_clock_out;
    assign sclk_fall = adv & sclk_hit & shift_clock_out;
    assign video_sync_clock_out_hit  = (video_sync_clock_out_cnt == reg_oclk[`PPL_OCLK_VIDEO_SYNC_CLOCK_OUT]);
    assign video_sync_clock_out_fall = video_sync_clock_out_hit & video_sync_clock_out;

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            sclk_cnt        <= {`PPL_DIV_W{1'b0}};
            shift_clock_out <= 1'b0;
        end
        else if (!sclk_run)
        begin
            sclk_cnt        <= {`PPL_DIV_W{1'b0}};
            shift_clock_out <= 1'b0;
        end
        else if (adv)
        begin
            if (sclk_hit)
            begin
                sclk_cnt        <= {`PPL_DIV_W{1'b0}};
                shift_clock_out <= ~shift_clock_out;
            end
            else
                sclk_cnt <= sclk_cnt + 1'b1;
        end
    end

    // Video clock runs freely so the processor always has a reference
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            video_sync_clock_out_cnt             <= {`PPL_DIV_W{1'b0}};
            video_sync_clock_out <= 1'b0;
        end
        else if (video_sync_clock_out_hit)
        begin
            video_sync_clock_out_cnt             <= {`PPL_DIV_W{1'b0}};
            video_sync_clock_out <= ~video_sync_clock_out;
        end
        else
            video_sync_clock_out_cnt <= video_sync_clock_out_cnt + 1'b1;
    end

    // ****************************************************************
    // Split transfer and nibble flag handling
    // ****************************************************************
    always @(posedge clock)
    begin
        if (!resetn)
        begin
            flag_q     <= 1'b0;
            extra_pend <= 1'b0;
            nibble_sel <= 1'b0;
        end
        else
        begin
            flag_q <= flag_s;
            // A new request in the finishing cycle wins over the clear
            if (extra_set)
                extra_pend <= 1'b1;
            else if (extra_clr || !split_mode)
                extra_pend <= 1'b0;
            if (nib_mode && video_sync_clock_out_fall)
                nibble_sel <= flag_s;
        end
    end

    // ****************************************************************
    // Pixel latch into the output buffer
    // ****************************************************************
    // Palette holds sixteen colours, so only the low nibble indexes it
    assign pix_idx  = passthru ? passthru_bus[`PPL_PAL_IDX] :
                      nib_mode ? nib_pick(pixel_bus[7:0], nibble_sel) :
                      pixel_bus[`PPL_PAL_IDX];
    assign pal_idx  = pix_idx & reg_mask[`PPL_PAL_IDX];
    assign pix_push = sclk_rise & ~blank_act;
    assign pix_word = dac_fmt(palette[pal_idx], wide_s);

    ppl_buf2 #(
        .WIDTH     (`PPL_COLOR_W)
    ) u_buf (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (pix_word),
        .in_valid  (pix_push),
        .in_ready  (buf_in_ready),
        .out_data  (dac_data),
        .out_valid (dac_valid),
        .out_ready (dac_ready)
    );

    // ****************************************************************
    // Host register port
    // ****************************************************************
    assign wr_blue = reg_wr && (reg_addr == `PPL_REG_HOLD) && (wr_cnt == `PPL_CNT_BLUE);
    assign rd_blue = reg_rd && (reg_addr == `PPL_REG_HOLD) && (rd_cnt == `PPL_CNT_BLUE);

    // Holding byte for reads; narrow mode hides the top two bits
    always @*
    begin
        case (rd_cnt)
            `PPL_CNT_RED: hold_byte = rd_hold[23:16];
            `PPL_CNT_GRN: hold_byte = rd_hold[15:8];
            default:      hold_byte = rd_hold[7:0];
        endcase
        if (!wide_s)
            hold_byte = {2'b00, hold_byte[`PPL_HOST_LOW6]};
    end

    // Palette storage keeps all eight bits whatever the width mode
    always @(posedge clock)
    begin
        if (wr_blue)
            palette[wr_addr] <= {wr_red, wr_grn, reg_wdata};
    end

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            reg_gctl  <= `PPL_GCTL_RST;
            reg_oclk  <= `PPL_OCLK_RST;
            reg_muxc  <= `PPL_MUXC_RST;
            reg_mask  <= `PPL_MASK_RST;
            wr_addr   <= {`PPL_PAL_AW{1'b0}};
            rd_addr   <= {`PPL_PAL_AW{1'b0}};
            wr_cnt    <= `PPL_CNT_RED;
            rd_cnt    <= `PPL_CNT_RED;
            wr_red    <= `PPL_BYTE_ZERO;
            wr_grn    <= `PPL_BYTE_ZERO;
            rd_hold   <= {`PPL_COLOR_W{1'b0}};
            reg_rdata <= `PPL_BYTE_ZERO;
        end
        else
        begin
            reg_rdata <= `PPL_BYTE_ZERO;
            if (reg_wr)
            begin
                case (reg_addr)
                    `PPL_REG_WADDR:
                    begin
                        wr_addr <= reg_wdata[`PPL_PAL_IDX];
                        wr_cnt  <= `PPL_CNT_RED;
                    end
                    `PPL_REG_HOLD:
                    begin
                        if (wr_cnt == `PPL_CNT_RED)
                            wr_red <= reg_wdata;
                        if (wr_cnt == `PPL_CNT_GRN)
                            wr_grn <= reg_wdata;
                        if (wr_blue)
                        begin
                            wr_cnt  <= `PPL_CNT_RED;
                            wr_addr <= wr_addr + 1'b1;
                        end
                        else
                            wr_cnt <= wr_cnt + 1'b1;
                    end
                    `PPL_REG_MASK:  reg_mask <= reg_wdata;
                    `PPL_REG_RADDR:
                    begin
                        rd_hold <= palette[reg_wdata[`PPL_PAL_IDX]];
                        rd_addr <= reg_wdata[`PPL_PAL_IDX] + 1'b1;
                        rd_cnt  <= `PPL_CNT_RED;
                    end
                    `PPL_REG_GCTL:  reg_gctl <= reg_wdata;
                    `PPL_REG_OCLK:  reg_oclk <= reg_wdata;
                    `PPL_REG_MUXC:  reg_muxc <= reg_wdata;
                    default:        reg_mask <= reg_mask;
                endcase
            end
            else if (reg_rd)
            begin
                case (reg_addr)
                    `PPL_REG_WADDR: reg_rdata <= {4'h0, wr_addr};
                    `PPL_REG_HOLD:
                    begin
                        reg_rdata <= hold_byte;
                        if (rd_blue)
                        begin
                            rd_hold <= palette[rd_addr];
                            rd_addr <= rd_addr + 1'b1;
                            rd_cnt  <= `PPL_CNT_RED;
                        end
                        else
                            rd_cnt <= rd_cnt + 1'b1;
                    end
                    `PPL_REG_MASK:  reg_rdata <= reg_mask;
                    `PPL_REG_RADDR: reg_rdata <= {4'h0, rd_addr};
                    `PPL_REG_GCTL:  reg_rdata <= reg_gctl;
                    `PPL_REG_OCLK:  reg_rdata <= reg_oclk;
                    `PPL_REG_MUXC:  reg_rdata <= reg_muxc;
                    default:        reg_rdata <= `PPL_BYTE_ZERO;
                endcase
            end
        end
    end

endmodule

// ===== verification/ppl_top_checker.sv
// Concurrent checks on the ports of the palette pixel-latch block.
// Assumes one dot clock with synchronous active-low reset; bound at the foot.
`include "ppl_defs.vh"

module ppl_top_checker (
    input logic        clock,
    input logic        resetn,
    input logic [3:0]  reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_rdata,
    input logic        width_select_in,
    input logic        split_or_nibble_flag,
    input logic        blank_n_in,
    input logic        alternate_retrace_gate_in,
    input logic        shift_clock_out,
    input logic [23:0] dac_data,
    input logic        dac_valid,
    input logic        dac_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********************
    // Mode shadow
    // ********************
    // Host writes shadow the mode registers
    logic [7:0] gctl_m;
    logic [7:0] muxc_m;
    logic       pass_m;
    assign pass_m = (muxc_m == `PPL_MUX_PASSTHRU);

    always @(posedge clock)
    begin
        if (!resetn)
        begin
            gctl_m <= `PPL_GCTL_RST;
            muxc_m <= `PPL_MUXC_RST;
        end
        else if (reg_wr && reg_addr == `PPL_REG_GCTL)
            gctl_m <= reg_wdata;
        else if (reg_wr && reg_addr == `PPL_REG_MUXC)
            muxc_m <= reg_wdata;
    end

    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_gctl_read;
        reg_rd && reg_addr == `PPL_REG_GCTL |=> reg_rdata == $past(gctl_m);
    endproperty
    a_gctl_read: assert property (p_gctl_read) else $error("gctl read wrong");

    property p_dac_six;
        (!width_select_in)[*8] ##1 $rose(dac_valid) |->
            dac_data[1:0] == 2'h0 && dac_data[9:8] == 2'h0 && dac_data[17:16] == 2'h0;
    endproperty
    a_dac_six: assert property (p_dac_six) else $error("dac low bits set");

    property p_hold_six;
        (!width_select_in)[*6] ##1 (reg_rd && reg_addr == `PPL_REG_HOLD)
            |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_hold_six: assert property (p_hold_six) else $error("hold top bits set");

    property p_blank_off;
        (!blank_n_in && !pass_m && gctl_m[3:2] != 2'h1)[*8] |-> !shift_clock_out;
    endproperty
    a_blank_off: assert property (p_blank_off) else $error("shift in blank");

    property p_alt_blank;
        (alternate_retrace_gate_in && pass_m && gctl_m[3:2] == 2'h0)[*8]
            |-> !shift_clock_out;
    endproperty
    a_alt_blank: assert property (p_alt_blank) else $error("shift in alt blank");

    property p_split_extra;
        (gctl_m[3:2] == 2'h1 && !blank_n_in && !pass_m)[*8] ##0
            $rose(split_or_nibble_flag) |-> ##[2:8] $rose(shift_clock_out);
    endproperty
    a_split_extra: assert property (p_split_extra) else $error("no extra shift");

    property p_flag_ignored;
        (gctl_m[3:2] == 2'h0 && !blank_n_in && !pass_m)[*8] ##0
            $rose(split_or_nibble_flag) |=> (!shift_clock_out)[*8];
    endproperty
    a_flag_ignored: assert property (p_flag_ignored) else $error("flag not ignored");

    property p_stall_hold;
        dac_valid && !dac_ready |=> dac_valid && $stable(dac_data);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("word lost in stall");
endmodule

bind ppl_top ppl_top_checker u_chk (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .width_select_in, .split_or_nibble_flag, .blank_n_in,
    .alternate_retrace_gate_in, .shift_clock_out, .dac_data, .dac_valid, .dac_ready);

// ===== verification/ppl_pixel_source.sv
// Video memory and colour sink on the pixel side.
// Assumes the bench sets the next pixel words and the stall mode.
module ppl_pixel_source (
    input  logic        clock,
    input  logic        shift_clock_out,
    input  logic [31:0] pix_word,
    input  logic [7:0]  pass_word,
    input  logic        stall,
    input  logic        slow,
    output logic [31:0] pixel_bus,
    output logic [7:0]  passthru_bus,
    output logic        dac_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    logic shift_q;

    // Memory shifts its next word out on each shift rise, as a real one does
    always @(posedge clock)
    begin
        shift_q <= shift_clock_out;
        if (shift_clock_out && !shift_q)
        begin
            pixel_bus <= pix_word;
            passthru_bus <= pass_word;
        end
        dac_ready <= !stall && !(slow && dac_ready);
    end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the palette pixel-latch block.
// Assumes the checker is bound to the design and the pixel source model.
`include "ppl_defs.vh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        width_select_in = 1'b1;
    logic        split_or_nibble_flag = 1'b0;
    logic        blank_n_in = 1'b1;
    logic        alternate_retrace_gate_in = 1'b0;
    logic [31:0] pix_word = 32'h0000_00A5;
    logic [7:0]  pass_word = 8'h03;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    wire  [7:0]  reg_rdata;
    wire  [31:0] pixel_bus;
    wire  [7:0]  passthru_bus;
    wire         shift_clock_out;
    wire         video_sync_clock_out;
    wire  [23:0] dac_data;
    wire         dac_valid;
    wire         dac_ready;
    int          num_errors = 0;
    int          comparisons = 0;

    always #5 clock = ~clock;

    ppl_top dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .width_select_in, .split_or_nibble_flag, .blank_n_in, .alternate_retrace_gate_in,
        .pixel_bus, .passthru_bus, .shift_clock_out, .video_sync_clock_out, .dac_data,
        .dac_valid, .dac_ready);

    ppl_pixel_source u_src (.clock, .shift_clock_out, .pix_word, .pass_word, .stall, .slow,
        .pixel_bus, .passthru_bus, .dac_ready);

    // ********************
    // Tasks
    // ********************
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
        @(posedge clock);
    endtask

    task automatic load(input logic [3:0] idx, input logic [23:0] c);
        wr(`PPL_REG_WADDR, {4'h0, idx});
        wr(`PPL_REG_HOLD, c[23:16]);
        wr(`PPL_REG_HOLD, c[15:8]);
        wr(`PPL_REG_HOLD, c[7:0]);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
    endtask

    // Stale buffered words are flushed first; a word never shown fails
    task automatic dac_chk(input logic [23:0] exp, input string what);
        repeat (16) @(posedge clock);
        #1;
        for (int k = 0; k < 50 && dac_valid !== 1'b1; k++)
        begin
            @(posedge clock);
            #1;
        end
        check(what, exp, (dac_valid === 1'b1) ? dac_data : 24'hX);
        @(posedge clock);
    endtask

    task automatic rises(input bit vid, input int cycles, input logic [23:0] exp,
                         input string what);
        logic [23:0] r;
        logic        q;
        logic        s;
        r = 24'h0;
        #1;
        q = vid ? video_sync_clock_out : shift_clock_out;
        repeat (cycles)
        begin
            @(posedge clock);
            #1;
            s = vid ? video_sync_clock_out : shift_clock_out;
            if (s && !q)
                r = r + 24'h1;
            q = s;
        end
        check(what, exp, r);
        @(posedge clock);
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ********************
    // Tests
    // ********************
    initial
    begin
        cyc(8);
        resetn <= 1'b1;
        cyc(4);
        rd(`PPL_REG_GCTL, `PPL_GCTL_RST, "gctl reset");
        rd(`PPL_REG_OCLK, `PPL_OCLK_RST, "oclk reset");
        rd(`PPL_REG_MUXC, `PPL_MUXC_RST, "muxc reset");
        rd(`PPL_REG_MASK, `PPL_MASK_RST, "mask reset");
        rd(4'h4, 8'h00, "unmapped");
        load(4'h5, 24'hABCDEF);
        load(4'hA, 24'h123456);
        load(4'h3, 24'hC1C2C3);
        wr(`PPL_REG_RADDR, 8'h05);
        rd(`PPL_REG_HOLD, 8'hAB, "hold red");
        rd(`PPL_REG_HOLD, 8'hCD, "hold green");
        rd(`PPL_REG_HOLD, 8'hEF, "hold blue");
        width_select_in <= 1'b0;
        cyc(8);
        wr(`PPL_REG_RADDR, 8'h05);
        rd(`PPL_REG_HOLD, 8'h2B, "hold red six");
        rd(`PPL_REG_HOLD, 8'h0D, "hold green six");
        rd(`PPL_REG_HOLD, 8'h2F, "hold blue six");
        dac_chk(24'hAC34BC, "dac six bit");
        width_select_in <= 1'b1;
        dac_chk(24'hABCDEF, "dac wide");
        slow <= 1'b1;
        dac_chk(24'hABCDEF, "dac slow sink");
        slow <= 1'b0;
        wr(`PPL_REG_GCTL, 8'h08);
        rd(`PPL_REG_GCTL, 8'h08, "gctl nibble");
        split_or_nibble_flag <= 1'b1;
        dac_chk(24'h123456, "upper nibble");
        split_or_nibble_flag <= 1'b0;
        dac_chk(24'hABCDEF, "lower nibble");
        wr(`PPL_REG_GCTL, 8'h04);
        blank_n_in <= 1'b0;
        cyc(8);
        rises(1'b0, 20, 24'h0, "shift in blank");
        split_or_nibble_flag <= 1'b1;
        rises(1'b0, 20, 24'h1, "split extra");
        split_or_nibble_flag <= 1'b0;
        cyc(8);
        wr(`PPL_REG_GCTL, 8'h00);
        cyc(8);
        split_or_nibble_flag <= 1'b1;
        rises(1'b0, 20, 24'h0, "flag ignored");
        split_or_nibble_flag <= 1'b0;
        blank_n_in <= 1'b1;
        wr(`PPL_REG_MUXC, `PPL_MUX_PASSTHRU);
        dac_chk(24'hC1C2C3, "pass-through pixel");
        blank_n_in <= 1'b0;
        cyc(8);
        rises(1'b0, 20, 24'hA, "normal blank unused");
        alternate_retrace_gate_in <= 1'b1;
        cyc(8);
        rises(1'b0, 20, 24'h0, "alternate blank");
        alternate_retrace_gate_in <= 1'b0;
        blank_n_in <= 1'b1;
        wr(`PPL_REG_MUXC, 8'h00);
        wr(`PPL_REG_OCLK, 8'h11);
        cyc(8);
        rises(1'b1, 48, 24'h8, "video period");
        rises(1'b0, 48, 24'hC, "shift period");
        wr(`PPL_REG_OCLK, 8'h00);
        stall <= 1'b1;
        cyc(20);
        rises(1'b0, 10, 24'h0, "frozen shift");
        check("held word", 24'h1, {23'h0, dac_valid});
        stall <= 1'b0;
        dac_chk(24'hABCDEF, "after stall");
        print_verdict();
    end

    // Tests need about five hundred cycles
    initial
    begin
        #100us;
        num_errors++;
        print_verdict();
    end
endmodule
